/* File: hdl/cti_cfg.svh */
/*
  Register offsets, field positions and reset values of the crystal
  trimmed interval timer.
  Assumes the CPU reaches these registers over its byte-wide
  special-function register port.
*/
`ifndef CTI_CFG_SVH
`define CTI_CFG_SVH

// Register offsets on the special-function register port
`define CTI_ADDR_OPTION 8'h94
`define CTI_ADDR_INTFLAGS 8'h95
`define CTI_ADDR_CNT_UPPER 8'hB3
`define CTI_ADDR_CNT_LOW 8'hB4
`define CTI_ADDR_CNT_MID 8'hB5
`define CTI_ADDR_RELOAD 8'hB6
`define CTI_ADDR_TRIM 8'hB7
`define CTI_ADDR_AUX 8'hF8

// Field positions
`define CTI_RATE_LSB 0
`define CTI_RATE_MSB 1
`define CTI_FLAG_BIT 0
`define CTI_TRIM_SIGN_BIT 7
`define CTI_TRIM_MAG_MSB 6
`define CTI_CLR_BIT 2

// Count bits whose carry marks 32768, 16384 and 8192 crystal cycles
`define CTI_CARRY_1S 15
`define CTI_CARRY_HALF 14
`define CTI_CARRY_QUARTER 13

// Reset values and unmapped read data
`define CTI_RATE_RST 2'b01
`define CTI_RELOAD_RST 8'h00
`define CTI_TRIM_RST 8'h00
`define CTI_UNMAPPED_RDATA 8'h00

`endif

/* File: hdl/cti_pkg.sv */
/*
  Types of the crystal trimmed interval timer.
  Assumes nothing of its surroundings.
*/
package cti_pkg;

  // Interrupt rate select codes
  typedef enum logic [1:0] {
    CTI_RATE_OVF = 2'b00,
    CTI_RATE_1S = 2'b01,
    CTI_RATE_HALF = 2'b10,
    CTI_RATE_QUARTER = 2'b11
  } cti_rate_e;

  // Count step per crystal cycle: 0, 1 or 2
  typedef logic [1:0] cti_step_t;

endpackage

/* File: hdl/cti_timer.sv */
/*
  Crystal trimmed interval timer: 23-bit counter stepped by the 32768 Hz
  crystal clock, upper-byte reload, rate trim, periodic interrupt flag and
  its special-function registers.
  Assumes a single 40 MHz CPU clock; the crystal clock is a plain input
  sampled here, and the CPU register port is synchronous to clk.
*/
`timescale 1ns/10ps
`include "cti_cfg.svh"

//Function
// - 23-bit counter advances on the 32768 Hz crystal clock, not the CPU clock.
// - On overflow, count bits 22..15 load from the resettable reload register.
// - With zero trim magnitude the count steps by one each crystal cycle.
// - Positive trim steps the count by two on selected crystal cycles.
// - Negative trim holds the count on selected crystal cycles.
// - Trim bit 7 chooses direction: 0 faster, 1 slower.
// - Trim bits 6..0 set the magnitude, 0.477 ppm per step.
// - Writing one to the clear control bit zeroes the count.
// - Rate select picks overflow, 32768, 16384 or 8192 crystal cycles.
// - Hardware sets the interval flag when the chosen interval is reached.
// - Entering the interrupt service routine clears the interval flag.
// - Writing FEh to the flag register clears bit 0 only.
// - Count readable as low byte, seven-bit mid byte and upper byte.
// - The interval flag is set in the clk domain; crystal edges are caught only while clk runs well above 32768 Hz.
module cti_timer #(
  parameter int COUNT_W = 23,
  parameter int RELOAD_W = 8,
  parameter int TRIM_FRAC_W = 21
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic crystal_clock_32k,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic isr_enter,
  output logic interval_interrupt_flag
);

  localparam int LOW_W = COUNT_W - RELOAD_W;

  // Reset release
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  wire rst_n = rst_sync_q;

  // Crystal clock sampling
  logic xtal_meta_q;
  logic xtal_sync_q;
  logic xtal_prev_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xtal_meta_q <= 1'b0;
      xtal_sync_q <= 1'b0;
      xtal_prev_q <= 1'b0;
    end
    else
    begin
      xtal_meta_q <= crystal_clock_32k;
      xtal_sync_q <= xtal_meta_q;
      xtal_prev_q <= xtal_sync_q;
    end
  end

  // One tick per crystal rising edge
  wire xtal_tick = xtal_sync_q & ~xtal_prev_q;

  // Register decode
  wire wr_option = sfr_wr & (sfr_addr == `CTI_ADDR_OPTION);
  wire wr_intflags = sfr_wr & (sfr_addr == `CTI_ADDR_INTFLAGS);
  wire wr_reload = sfr_wr & (sfr_addr == `CTI_ADDR_RELOAD);
  wire wr_trim = sfr_wr & (sfr_addr == `CTI_ADDR_TRIM);
  wire wr_aux = sfr_wr & (sfr_addr == `CTI_ADDR_AUX);

  // Software-written controls
  logic [1:0] rate_q;
  logic [RELOAD_W-1:0] reload_q;
  logic [7:0] trim_q;
  logic clear_req_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rate_q <= `CTI_RATE_RST;
    end
    else if (wr_option)
    begin
      rate_q <= sfr_wdata[`CTI_RATE_MSB:`CTI_RATE_LSB];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reload_q <= RELOAD_W'(`CTI_RELOAD_RST);
    end
    else if (wr_reload)
    begin
      reload_q <= RELOAD_W'(sfr_wdata);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trim_q <= `CTI_TRIM_RST;
    end
    else if (wr_trim)
    begin
      trim_q <= sfr_wdata;
    end
  end

  // Clear request is a one-cycle pulse, the bit reads back zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clear_req_q <= 1'b0;
    end
    else
    begin
      clear_req_q <= wr_aux & sfr_wdata[`CTI_CLR_BIT];
    end
  end

  // Trim fields
  // Sign selects direction
  wire trim_sign = trim_q[`CTI_TRIM_SIGN_BIT];
  wire [6:0] trim_magnitude = trim_q[`CTI_TRIM_MAG_MSB:0];
  wire trim_zero = (trim_magnitude == 7'h00);

  // Phase accumulator spreading the corrections
  logic [TRIM_FRAC_W-1:0] phase_q;
  logic [TRIM_FRAC_W:0] phase_sum;
  logic trim_hit;

  // Magnitude corrections per 2^21 crystal cycles
  assign phase_sum = {1'b0, phase_q} + (TRIM_FRAC_W+1)'(trim_magnitude);
  assign trim_hit = phase_sum[TRIM_FRAC_W];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_q <= '0;
    end
    else if (clear_req_q)
    begin
      phase_q <= '0;
    end
    else if (xtal_tick)
    begin
      phase_q <= phase_sum[TRIM_FRAC_W-1:0];
    end
  end

  // Count step for this crystal cycle
  cti_pkg::cti_step_t step;

  always_comb
  begin
    step = 2'd1;
    if (trim_zero || !trim_hit)
    begin
      step = 2'd1;
    end
    else if (trim_sign)
    begin
      step = 2'd0;
    end
    else
    begin
      step = 2'd2;
    end
  end

  // Counter
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  logic [COUNT_W:0] count_sum;
  logic overflow;

  assign count_sum = {1'b0, count_q} + (COUNT_W+1)'(step);
  assign overflow = count_sum[COUNT_W];

  always_comb
  begin
    count_d = count_q;
    if (clear_req_q)
    begin
      count_d = '0;
    end
    else if (xtal_tick && overflow)
    begin
      count_d = {reload_q, count_sum[LOW_W-1:0]};
    end
    else if (xtal_tick)
    begin
      count_d = count_sum[COUNT_W-1:0];
    end
  end

  // Count register, advanced only by crystal ticks
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  // Interval detection: carry into a count bit marks the period boundary
  wire carry_1s = count_sum[`CTI_CARRY_1S] ^ count_q[`CTI_CARRY_1S];
  wire carry_half = count_sum[`CTI_CARRY_HALF] ^ count_q[`CTI_CARRY_HALF];
  wire carry_quarter = count_sum[`CTI_CARRY_QUARTER] ^ count_q[`CTI_CARRY_QUARTER];
  logic interval_hit;

  // Rate select picks the interval source
  always_comb
  begin
    interval_hit = 1'b0;
    unique case (cti_pkg::cti_rate_e'(rate_q))
      cti_pkg::CTI_RATE_OVF:
        interval_hit = overflow;
      cti_pkg::CTI_RATE_1S:
        interval_hit = carry_1s;
      cti_pkg::CTI_RATE_HALF:
        interval_hit = carry_half;
      cti_pkg::CTI_RATE_QUARTER:
        interval_hit = carry_quarter;
    endcase
  end

  wire interval_event = xtal_tick & interval_hit & ~clear_req_q;

  // Interval interrupt flag
  // Service entry clears the flag
  // Writing zero to bit 0 clears it, other bits untouched
  wire flag_clear = isr_enter | (wr_intflags & ~sfr_wdata[`CTI_FLAG_BIT]);
  logic flag_q;

  // Set by the interval event; the set wins over a clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q <= 1'b0;
    end
    else if (interval_event)
    begin
      flag_q <= 1'b1;
    end
    else if (flag_clear)
    begin
      flag_q <= 1'b0;
    end
  end

  assign interval_interrupt_flag = flag_q;

  // Read data
  logic [7:0] rd_mux;

  // Count bytes, mid byte holds seven bits
  always_comb
  begin
    rd_mux = `CTI_UNMAPPED_RDATA;
    unique case (sfr_addr)
      `CTI_ADDR_OPTION:
        rd_mux = {6'h00, rate_q};
      `CTI_ADDR_INTFLAGS:
        rd_mux = {7'h00, flag_q};
      `CTI_ADDR_CNT_UPPER:
        rd_mux = count_q[COUNT_W-1:LOW_W];
      `CTI_ADDR_CNT_LOW:
        rd_mux = count_q[7:0];
      `CTI_ADDR_CNT_MID:
        rd_mux = {1'b0, count_q[LOW_W-1:8]};
      `CTI_ADDR_RELOAD:
        rd_mux = reload_q;
      `CTI_ADDR_TRIM:
        rd_mux = trim_q;
      `CTI_ADDR_AUX:
        rd_mux = 8'h00;
      default:
        rd_mux = `CTI_UNMAPPED_RDATA;
    endcase
  end

  logic [7:0] rdata_q;

  // Read data is captured on the read strobe and held
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 8'h00;
    end
    else if (sfr_rd)
    begin
      rdata_q <= rd_mux;
    end
  end

  assign sfr_rdata = rdata_q;

endmodule

/* File: tb/cti_timer_properties.sv */
/* Port checker for the interval timer.
   Assumes it is bound to cti_timer and sees only its ports. */
`timescale 1ns/10ps
module cti_timer_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic crystal_clock_32k,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic isr_enter,
  input wire logic interval_interrupt_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire flag_clr = sfr_wr && sfr_addr == 8'h95 && !sfr_wdata[0];
  wire mapped = sfr_addr inside {8'h94, 8'h95, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hF8};
  wire flag = interval_interrupt_flag;
  // Crystal levels of the last three clocks, to see a tick inside the timer
  logic [2:0] xtal_hist;
  always_ff @(posedge clk)
  begin
    xtal_hist <= {xtal_hist[1:0], crystal_clock_32k};
  end
  // Rising crystal edge that the timer acts on at this clock; a set then wins over a clear
  wire tick_seen = xtal_hist[1] & ~xtal_hist[2];
  a_isr_clears_flag: assert property (isr_enter && !tick_seen |=> !flag)
    else $error("flag survived service entry");
  a_write_clears_flag: assert property (flag_clr && !tick_seen |=> !flag)
    else $error("flag survived clear write");
  a_flag_holds: assert property (flag && !isr_enter && !flag_clr |=> flag)
    else $error("flag dropped by itself");
  a_flag_after_crystal: assert property ($rose(flag) |-> $past(tick_seen))
    else $error("flag rose without crystal edge");
  a_rdata_stands: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without read");
  a_mid_top_zero: assert property (sfr_rd && sfr_addr == 8'hB5 |=> !sfr_rdata[7])
    else $error("mid byte bit 7 set");
  a_unmapped_zero: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_clear_reads_zero: assert property (sfr_rd && sfr_addr == 8'hF8 |=> sfr_rdata == 8'h00)
    else $error("clear register read not zero");
  a_rate_upper_zero: assert property (sfr_rd && sfr_addr == 8'h94 |=> sfr_rdata[7:2] == 6'h00)
    else $error("rate register upper bits set");
endmodule
bind cti_timer cti_timer_props u_props (.clk(clk), .reset_n(reset_n), .crystal_clock_32k(crystal_clock_32k),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .isr_enter(isr_enter), .interval_interrupt_flag(interval_interrupt_flag));

/* File: tb/cti_timer_bench.sv */
/* Self-checking bench for the interval timer.
   Assumes the crystal input may be stepped fast, three clocks per level. */
`timescale 1ns/10ps
module cti_timer_bench;
  logic clk, reset_n, xtal, sfr_wr, sfr_rd, isr_enter, flag;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  int bad_count, comparisons;
  // Write flag, address, data, expected read
  logic [24:0] rows [8] = '{{1'b1, 24'hB6A5A5}, {1'b1, 24'hB7FFFF}, {1'b1, 24'h94FF03}, {1'b1, 24'hB45500},
    {1'b1, 24'hF8FF00}, {1'b0, 24'hB30000}, {1'b1, 24'h107700}, {1'b1, 24'h95FE00}};
  // Trim value, expected low byte after 60 ticks
  logic [15:0] trims [3] = '{16'h003C, 16'h053E, 16'h853A};
  cti_timer #(.TRIM_FRAC_W(7)) DUT (.clk(clk), .reset_n(reset_n), .crystal_clock_32k(xtal),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .isr_enter(isr_enter), .interval_interrupt_flag(flag));
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task chk(input logic [7:0] got, input logic [7:0] e);
    comparisons++;
    if (got !== e)
    begin
      bad_count++;
      $display("ERROR %0t: read %h expected %h", $time, got, e);
    end
  endtask
  task chkf(input logic e);
    @(posedge clk);
    #1;
    comparisons++;
    if (flag !== e)
    begin
      bad_count++;
      $display("ERROR %0t: flag %b expected %b", $time, flag, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1;
    @(posedge clk);
    sfr_wr <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1;
    @(posedge clk);
    sfr_rd <= 0;
    @(posedge clk);
    #1;
    chk(sfr_rdata, e);
  endtask
  task xtick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      xtal <= 1;
      repeat (3) @(posedge clk);
      xtal <= 0;
      repeat (2) @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #2300000;
    bad_count++;
    end_of_test;
  end
  initial
  begin
    reset_n = 0;
    xtal = 0;
    sfr_wr = 0;
    sfr_rd = 0;
    isr_enter = 0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    repeat (8) @(posedge clk);
    reset_n <= 1;
    repeat (3) @(posedge clk);
    foreach (rows[i])
    begin
      if (rows[i][24])
        wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    // Second reset restores the writable registers
    @(posedge clk);
    reset_n <= 0;
    repeat (3) @(posedge clk);
    reset_n <= 1;
    repeat (3) @(posedge clk);
    rd(8'hB6, 8'h00);
    rd(8'hB7, 8'h00);
    rd(8'h94, 8'h01);
    wr(8'h94, 8'h03);
    foreach (trims[i])
    begin
      wr(8'hB7, trims[i][15:8]);
      wr(8'hF8, 8'h04);
      xtick(60);
      rd(8'hB4, trims[i][7:0]);
    end
    wr(8'hB7, 8'h00);
    wr(8'hF8, 8'h04);
    xtick(8191);
    chkf(0);
    xtick(1);
    chkf(1);
    rd(8'hB4, 8'h00);
    rd(8'hB5, 8'h20);
    rd(8'hB3, 8'h00);
    wr(8'h95, 8'hFF);
    chkf(1);
    wr(8'h95, 8'hFE);
    chkf(0);
    wr(8'hB7, 8'h7F);
    wr(8'h94, 8'h00);
    xtick(4100);
    chkf(0);
    wr(8'h94, 8'h02);
    xtick(100);
    chkf(1);
    @(posedge clk);
    isr_enter <= 1;
    @(posedge clk);
    isr_enter <= 0;
    chkf(0);
    // Software filter: two equal reads of a still count
    rd(8'hB4, 8'hAF);
    rd(8'hB4, 8'hAF);
    rd(8'hB5, 8'h40);
    end_of_test;
  end
endmodule
